// File: lvdiv_defs.vh
// constants for the high-speed channel clock divider block
`ifndef LVDIV_DEFS_VH
`define LVDIV_DEFS_VH
`define LVDIV_ADDR_W 9
`define LVDIV_DATA_W 8
`define LVDIV_CNT_W 5
`define LVDIV_OFF_C0_CYC 9'h190
`define LVDIV_OFF_C0_CTL 9'h191
`define LVDIV_OFF_C0_RTE 9'h192
`define LVDIV_OFF_C1_CYC 9'h196
`define LVDIV_OFF_C1_CTL 9'h197
`define LVDIV_OFF_C1_RTE 9'h198
`define LVDIV_OFF_STAT 9'h1F0
`define LVDIV_LOW_HI 7
`define LVDIV_LOW_LO 4
`define LVDIV_HIGH_HI 3
`define LVDIV_HIGH_LO 0
`define LVDIV_BYP_BIT 7
`define LVDIV_NOSYNC_BIT 6
`define LVDIV_FORCE_BIT 5
`define LVDIV_START_BIT 4
`define LVDIV_PHASE_HI 3
`define LVDIV_PHASE_LO 0
`define LVDIV_DIRECT_BIT 1
`define LVDIV_DUTY_CORRECTION_DISABLE_BIT 0
`define LVDIV_RTE_MASK 8'h03
`define LVDIV_C0_CYC_RST 8'h00
`define LVDIV_C0_CTL_RST 8'h80
`define LVDIV_C0_RTE_RST 8'h00
`define LVDIV_C1_CYC_RST 8'h00
`define LVDIV_C1_CTL_RST 8'h00
`define LVDIV_C1_RTE_RST 8'h00
`define LVDIV_SRC_EXT 2'h0
`define LVDIV_SRC_NONE 2'h1
`define LVDIV_SRC_OSC 2'h2
`define LVDIV_ST_IDLE 2'h0
`define LVDIV_ST_HOLD 2'h1
`define LVDIV_ST_RUN 2'h2
`define LVDIV_ST_FORCE 2'h3
`endif

// File: lvdiv_sync.v
// qualification of the chip-level sync request for both channel dividers
`timescale 1ns/1ns
`include "lvdiv_defs.vh"
module lvdiv_sync
(
  input wire core_clk,
  input wire rst_n,
  input wire sync_hold,
  input wire [1:0] nosync,
  input wire seen_clr,
  output wire [1:0] hold,
  output wire [1:0] force_now,
  output wire sync_seen
);
  reg sync_d_ff;
  reg seen_ff;
  wire nxt_seen;

  assign hold = {2{sync_hold}} & ~nosync;
  assign force_now = {2{sync_hold}} & nosync;

  // sticky flag; a new request in the clearing cycle wins
  assign nxt_seen = (sync_hold & ~sync_d_ff) | (seen_ff & ~seen_clr);

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_d_ff <= 1'b0;
      seen_ff <= 1'b0;
    end
    else
    begin
      sync_d_ff <= sync_hold;
      seen_ff <= nxt_seen;
    end
  end

  assign sync_seen = seen_ff;
endmodule

// File: lvdiv_route.v
// output pair source selection and retiming for one channel
`timescale 1ns/1ns
`include "lvdiv_defs.vh"
module lvdiv_route
(
  input wire core_clk,
  input wire rst_n,
  input wire div_level,
  input wire bypass,
  input wire direct,
  input wire [1:0] src_select,
  input wire dcc_off,
  input wire div_in_tick,
  input wire div_in_level,
  input wire osc_level,
  input wire ext_clk_level,
  output wire pair_out
);
  reg out_ff;
  reg nxt_out;
  reg from_div;

  always @*
  begin
    from_div = 1'b0;
    if (direct && src_select == `LVDIV_SRC_OSC)
      nxt_out = osc_level;
    else if (direct && src_select == `LVDIV_SRC_EXT)
      nxt_out = ext_clk_level;
    else if (bypass)
      nxt_out = div_in_level;
    else
    begin
      nxt_out = div_level;
      from_div = 1'b1;
    end
  end

  // correction retimes on input tick
  // retiming costs one input cycle of latency, traded for clean edges
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      out_ff <= 1'b0;
    else if (!(from_div && !dcc_off) || div_in_tick)
      out_ff <= nxt_out;
  end

  assign pair_out = out_ff;
endmodule

// File: lvdiv_top.v
// two high-speed channel clock dividers with their register file
// How it works
// - output stays low for low-cycle field plus one input cycles
// - output stays high for high-cycle field plus one input cycles
// - bypass powers divider down and passes its input clock through
// - channel 0 resets into bypass, channel 1 resets in use
// - nosync clear obeys chip sync, nosync set turns chip sync into forcing
// - while forcing, output equals force bit, high or low
// - start bit picks the level the divider begins toggling at
// - four-bit phase offset delays the waveform start in input cycles
// - direct bit routes oscillator or external clock to the pair
// - duty correction runs while its disable bit is clear
// - channel 1 has its own cycle, bypass, nosync, force controls
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`include "lvdiv_defs.vh"
module lvdiv_top
#(
  parameter CNT_W = `LVDIV_CNT_W
)
(
  input wire core_clk,
  input wire rst_n,
  input wire [`LVDIV_ADDR_W-1:0] reg_addr,
  input wire [`LVDIV_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [`LVDIV_DATA_W-1:0] reg_rdata,
  input wire div_in_tick,
  input wire div_in_level,
  input wire osc_level,
  input wire ext_clk_level,
  input wire [1:0] src_select,
  input wire sync_hold,
  output wire pair0_output_a,
  output wire pair0_output_b,
  output wire pair1_output_a,
  output wire pair1_output_b,
  output wire [1:0] dcc_active
);
  // configuration registers
  reg [7:0] c0_cyc_ff;
  reg [7:0] c0_ctl_ff;
  reg [7:0] c0_rte_ff;
  reg [7:0] c1_cyc_ff;
  reg [7:0] c1_ctl_ff;
  reg [7:0] c1_rte_ff;
  reg [7:0] rdata_ff;
  reg [7:0] nxt_rdata;

  // per channel views of the registers
  wire [7:0] cyc_w [0:1];
  wire [7:0] ctl_w [0:1];
  wire [7:0] rte_w [0:1];
  wire [1:0] nosync_w;
  wire [1:0] hold_w;
  wire [1:0] force_w;
  wire [1:0] lvl_w;
  wire [1:0] run_w;
  wire [1:0] pair_w;
  wire sync_seen_w;
  wire stat_clr;

  // duration in ticks minus one for a given level
  function [CNT_W-1:0] dur;
    input lvl;
    input [7:0] cyc;
    begin
      if (lvl)
        dur = {{(CNT_W-4){1'b0}}, cyc[`LVDIV_HIGH_HI:`LVDIV_HIGH_LO]};
      else
        dur = {{(CNT_W-4){1'b0}}, cyc[`LVDIV_LOW_HI:`LVDIV_LOW_LO]};
    end
  endfunction

  // first load: starting level time plus phase offset
  function [CNT_W-1:0] first_load;
    input [7:0] cyc;
    input [7:0] ctl;
    reg [CNT_W-1:0] ph;
    begin
      ph = {{(CNT_W-4){1'b0}}, ctl[`LVDIV_PHASE_HI:`LVDIV_PHASE_LO]};
      first_load = dur(ctl[`LVDIV_START_BIT], cyc) + ph;
    end
  endfunction

  assign cyc_w[0] = c0_cyc_ff;
  assign cyc_w[1] = c1_cyc_ff;
  assign ctl_w[0] = c0_ctl_ff;
  assign ctl_w[1] = c1_ctl_ff;
  assign rte_w[0] = c0_rte_ff;
  assign rte_w[1] = c1_rte_ff;
  assign nosync_w = {c1_ctl_ff[`LVDIV_NOSYNC_BIT], c0_ctl_ff[`LVDIV_NOSYNC_BIT]};

  // register writes, one byte per address
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c0_cyc_ff <= `LVDIV_C0_CYC_RST;
      c0_ctl_ff <= `LVDIV_C0_CTL_RST;
      c0_rte_ff <= `LVDIV_C0_RTE_RST;
      c1_cyc_ff <= `LVDIV_C1_CYC_RST;
      c1_ctl_ff <= `LVDIV_C1_CTL_RST;
      c1_rte_ff <= `LVDIV_C1_RTE_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `LVDIV_OFF_C0_CYC: c0_cyc_ff <= reg_wdata;
        `LVDIV_OFF_C0_CTL: c0_ctl_ff <= reg_wdata;
        `LVDIV_OFF_C0_RTE: c0_rte_ff <= reg_wdata & `LVDIV_RTE_MASK;
        `LVDIV_OFF_C1_CYC: c1_cyc_ff <= reg_wdata;
        `LVDIV_OFF_C1_CTL: c1_ctl_ff <= reg_wdata;
        `LVDIV_OFF_C1_RTE: c1_rte_ff <= reg_wdata & `LVDIV_RTE_MASK;
        default: c0_cyc_ff <= c0_cyc_ff;
      endcase
    end
  end

  // any write to the status address clears the sticky sync flag
  assign stat_clr = reg_wr && (reg_addr == `LVDIV_OFF_STAT);

  // read mux; unmapped addresses read zero
  always @*
  begin
    case (reg_addr)
      `LVDIV_OFF_C0_CYC: nxt_rdata = c0_cyc_ff;
      `LVDIV_OFF_C0_CTL: nxt_rdata = c0_ctl_ff;
      `LVDIV_OFF_C0_RTE: nxt_rdata = c0_rte_ff;
      `LVDIV_OFF_C1_CYC: nxt_rdata = c1_cyc_ff;
      `LVDIV_OFF_C1_CTL: nxt_rdata = c1_ctl_ff;
      `LVDIV_OFF_C1_RTE: nxt_rdata = c1_rte_ff;
      `LVDIV_OFF_STAT: nxt_rdata = {3'h0, sync_seen_w, run_w, lvl_w};
      default: nxt_rdata = 8'h00;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= 8'h00;
    else if (reg_rd)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= 8'h00;
  end

  assign reg_rdata = rdata_ff;

  lvdiv_sync u_sync
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sync_hold(sync_hold),
    .nosync(nosync_w),
    .seen_clr(stat_clr),
    .hold(hold_w),
    .force_now(force_w),
    .sync_seen(sync_seen_w)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_ch
      reg [1:0] st_ff;
      reg [1:0] nxt_st;
      reg [CNT_W-1:0] cnt_ff;
      reg [CNT_W-1:0] nxt_cnt;
      reg lvl_ff;
      reg nxt_lvl;
      wire byp;
      wire start_lvl;

      assign byp = ctl_w[gi][`LVDIV_BYP_BIT];
      assign start_lvl = ctl_w[gi][`LVDIV_START_BIT];

      // divider state machine; bypass wins over everything
      always @*
      begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_lvl = lvl_ff;
        case (st_ff)
          `LVDIV_ST_IDLE:
          begin
            nxt_lvl = 1'b0;
            nxt_cnt = {CNT_W{1'b0}};
            if (!byp)
            begin
              nxt_st = `LVDIV_ST_RUN;
              nxt_lvl = start_lvl;
              nxt_cnt = first_load(cyc_w[gi], ctl_w[gi]);
            end
          end
          `LVDIV_ST_HOLD:
          begin
            nxt_lvl = start_lvl;
            if (byp)
              nxt_st = `LVDIV_ST_IDLE;
            else if (!hold_w[gi])
            begin
              nxt_st = `LVDIV_ST_RUN;
              nxt_cnt = first_load(cyc_w[gi], ctl_w[gi]);
            end
          end
          `LVDIV_ST_RUN:
          begin
            if (byp)
              nxt_st = `LVDIV_ST_IDLE;
            else if (hold_w[gi])
              nxt_st = `LVDIV_ST_HOLD;
            else if (force_w[gi])
              nxt_st = `LVDIV_ST_FORCE;
            else if (div_in_tick)
            begin
              if (cnt_ff == {CNT_W{1'b0}})
              begin
                nxt_lvl = ~lvl_ff;
                nxt_cnt = dur(~lvl_ff, cyc_w[gi]);
              end
              else
                nxt_cnt = cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
            end
          end
          `LVDIV_ST_FORCE:
          begin
            nxt_lvl = ctl_w[gi][`LVDIV_FORCE_BIT];
            if (byp)
              nxt_st = `LVDIV_ST_IDLE;
            else if (!force_w[gi])
            begin
              nxt_st = `LVDIV_ST_RUN;
              nxt_lvl = start_lvl;
              nxt_cnt = first_load(cyc_w[gi], ctl_w[gi]);
            end
          end
          default:
            nxt_st = `LVDIV_ST_IDLE;
        endcase
      end

      // divider state, counter and level flops
      always @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          st_ff <= `LVDIV_ST_IDLE;
          cnt_ff <= {CNT_W{1'b0}};
          lvl_ff <= 1'b0;
        end
        else
        begin
          st_ff <= nxt_st;
          cnt_ff <= nxt_cnt;
          lvl_ff <= nxt_lvl;
        end
      end

      assign lvl_w[gi] = lvl_ff;
      assign run_w[gi] = (st_ff == `LVDIV_ST_RUN);
      assign dcc_active[gi] = ~rte_w[gi][`LVDIV_DUTY_CORRECTION_DISABLE_BIT];

      lvdiv_route u_route
      (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .div_level(lvl_ff),
        .bypass(byp),
        .direct(rte_w[gi][`LVDIV_DIRECT_BIT]),
        .src_select(src_select),
        .dcc_off(rte_w[gi][`LVDIV_DUTY_CORRECTION_DISABLE_BIT]),
        .div_in_tick(div_in_tick),
        .div_in_level(div_in_level),
        .osc_level(osc_level),
        .ext_clk_level(ext_clk_level),
        .pair_out(pair_w[gi])
      );
    end
  endgenerate

  // both outputs of a pair share one divider
  assign pair0_output_a = pair_w[0];
  assign pair0_output_b = pair_w[0];
  assign pair1_output_a = pair_w[1];
  assign pair1_output_b = pair_w[1];
endmodule

// File: lvdiv_chk.sv
// assertions for the channel divider block, bound to its top module
`timescale 1ns/1ns
module lvdiv_chk
#(
  parameter CNT_W = 5
)
(
  input wire core_clk,
  input wire rst_n,
  input wire [8:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire div_in_tick,
  input wire div_in_level,
  input wire osc_level,
  input wire ext_clk_level,
  input wire [1:0] src_select,
  input wire sync_hold,
  input wire pair0_output_a,
  input wire pair1_output_a,
  input wire [1:0] dcc_active
);
  reg [7:0] ctl0_ff, ctl1_ff, rte0_ff, rte1_ff;
  // shadow copies of the control registers, followed from bus writes
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl0_ff <= 8'h80;
      ctl1_ff <= 8'h00;
      rte0_ff <= 8'h00;
      rte1_ff <= 8'h00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 9'h191) ctl0_ff <= reg_wdata;
      if (reg_addr == 9'h197) ctl1_ff <= reg_wdata;
      if (reg_addr == 9'h192) rte0_ff <= reg_wdata & 8'h03;
      if (reg_addr == 9'h198) rte1_ff <= reg_wdata & 8'h03;
    end
  end
  // qualifiers; only ticking cycles count, since duty correction retimes to ticks
  wire run1 = sync_hold & div_in_tick & ~ctl1_ff[7] & ~rte1_ff[1];
  wire f1 = run1 & ctl1_ff[6];
  wire h1 = run1 & ~ctl1_ff[6];
  // source select 01 leaves a direct route without effect, so bypass still applies
  wire b0 = div_in_tick & ctl0_ff[7] & (~rte0_ff[1] | (src_select == 2'h1));
  wire d0 = div_in_tick & rte0_ff[1] & ~src_select[0];
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_ctl0_rd;
    $past(reg_rd && reg_addr == 9'h191) |-> reg_rdata == $past(ctl0_ff);
  endproperty
  a_ctl0_rd: assert property (p_ctl0_rd) else $error("ch0 control readback");
  property p_ctl1_rd;
    $past(reg_rd && reg_addr == 9'h197) |-> reg_rdata == $past(ctl1_ff);
  endproperty
  a_ctl1_rd: assert property (p_ctl1_rd) else $error("ch1 control readback");
  property p_bypass;
    $past(rst_n) && $past(b0) |-> pair0_output_a == $past(div_in_level);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not passing input");
  property p_direct;
    $past(d0) |-> pair0_output_a == $past(src_select[1] ? osc_level : ext_clk_level);
  endproperty
  a_direct: assert property (p_direct) else $error("direct route source");
  property p_dcc;
    dcc_active == ~{rte1_ff[0], rte0_ff[0]};
  endproperty
  a_dcc: assert property (p_dcc) else $error("duty correction state");
  property p_force;
    f1 [*5] |-> pair1_output_a == ctl1_ff[5];
  endproperty
  a_force: assert property (p_force) else $error("forced level wrong");
  property p_hold;
    h1 [*5] |-> pair1_output_a == ctl1_ff[4];
  endproperty
  a_hold: assert property (p_hold) else $error("sync hold level wrong");
endmodule
bind lvdiv_top lvdiv_chk #(.CNT_W(CNT_W)) i_lvdiv_chk (.core_clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .div_in_tick, .div_in_level, .osc_level,
  .ext_clk_level, .src_select, .sync_hold, .pair0_output_a, .pair1_output_a, .dcc_active);

// File: tb.sv
// self-checking bench for the two channel dividers
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
  reg core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, div_in_tick = 1, div_in_level = 0;
  reg osc_level = 0, ext_clk_level = 0, sync_hold = 0, half = 0;
  reg [8:0] reg_addr = 0;
  reg [7:0] reg_wdata = 0, cnt_ff = 0;
  reg [1:0] src_select = 2'h2;
  reg [3:0] hist;
  wire [7:0] reg_rdata;
  wire pair0_output_a, pair0_output_b, pair1_output_a, pair1_output_b;
  wire [1:0] dcc_active;
  wire [1:0] pv = {pair1_output_a, pair0_output_a};
  int err_total = 0, checked = 0, cyc_n = 0;
  int tch[4] = '{1, 0, 1, 0};
  reg [7:0] tcy[4] = '{8'h32, 8'h0F, 8'hF0, 8'h21};
  reg th[4] = '{0, 0, 0, 1};
  lvdiv_top i_lvdiv_top (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .div_in_tick, .div_in_level, .osc_level, .ext_clk_level, .src_select,
    .sync_hold, .pair0_output_a, .pair0_output_b, .pair1_output_a, .pair1_output_b,
    .dcc_active);
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end
  // source patterns at different rates so a wrong route shows; also the hang limit
  always @(posedge core_clk)
  begin
    cnt_ff <= cnt_ff + 8'h01;
    osc_level <= ~osc_level;
    ext_clk_level <= cnt_ff[1];
    div_in_level <= cnt_ff[2];
    div_in_tick <= half ? ~div_in_tick : 1'b1;
    cyc_n = cyc_n + 1;
    if (cyc_n == 6000)
    begin
      err_total++;
      stop_test;
    end
  end
  task wr(input [8:0] a, input [7:0] d);
  begin
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // step past the edge so register outputs are settled for any check
    #1;
  end
  endtask
  task rd(input [8:0] a, input [7:0] e);
  begin
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("rdata", e, reg_rdata)
  end
  endtask
  // restart all obeying dividers; ends just past an edge so levels are settled
  task sync(input int n);
  begin
    @(posedge core_clk);
    sync_hold <= 1'b1;
    repeat (n) @(posedge core_clk);
    sync_hold <= 1'b0;
    #1;
  end
  endtask
  // counts consecutive settled samples at one level on the chosen channel
  task runl(input int ch, input logic lv, input int e);
    int n;
    int k;
  begin
    n = 0;
    k = 0;
    while (pv[ch] !== lv && k < 80)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    while (pv[ch] === lv && n < 80)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `CHK("run length", e, n)
  end
  endtask
  task hold_chk(input [7:0] c, input logic e);
  begin
    wr(9'h197, c);
    @(posedge core_clk);
    sync_hold <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    `CHK("held level", e, pair1_output_a)
    `CHK("held level b", e, pair1_output_b)
    `CHK("ch0 held b", 1'b0, pair0_output_b)
    @(posedge core_clk);
    sync_hold <= 1'b0;
  end
  endtask
  task stop_test;
  begin
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(9'h191, 8'h80);
    rd(9'h197, 8'h00);
    rd(9'h190, 8'h00);
    rd(9'h196, 8'h00);
    rd(9'h100, 8'h00);
    repeat (16) @(posedge core_clk);
    wr(9'h192, 8'hFF);
    rd(9'h192, 8'h03);
    repeat (8) @(posedge core_clk);
    src_select <= 2'h0;
    repeat (8) @(posedge core_clk);
    // select 01 leaves the bypass path
    src_select <= 2'h1;
    repeat (8) @(posedge core_clk);
    wr(9'h192, 8'h01);
    `CHK("dcc", 2'b10, dcc_active)
    wr(9'h198, 8'h01);
    `CHK("dcc", 2'b00, dcc_active)
    wr(9'h191, 8'h00);
    // both channels in the divider path, length of each level per setting
    for (int i = 0; i < 4; i++)
    begin
      half <= th[i];
      wr(tch[i] ? 9'h196 : 9'h190, tcy[i]);
      sync(3);
      runl(tch[i], 1'b1, (tcy[i][3:0] + 1) * (th[i] + 1));
      runl(tch[i], 1'b0, (tcy[i][7:4] + 1) * (th[i] + 1));
    end
    half <= 1'b0;
    wr(9'h190, 8'h11);
    wr(9'h196, 8'h11);
    wr(9'h197, 8'h03);
    sync(3);
    hist = 4'h0;
    // channel 1 must trail channel 0 by its phase offset of three ticks
    for (int i = 0; i < 24; i++)
    begin
      if (i > 2) `CHK("phase", hist[2], pair1_output_a)
      hist = {hist[2:0], pair0_output_a};
      @(posedge core_clk);
      #1;
    end
    hold_chk(8'h60, 1'b1);
    hold_chk(8'h40, 1'b0);
    hold_chk(8'h10, 1'b1);
    hold_chk(8'h00, 1'b0);
    rd(9'h197, 8'h00);
    // both channels parked in bypass so the status levels are known
    wr(9'h191, 8'h80);
    wr(9'h197, 8'h80);
    repeat (2) @(posedge core_clk);
    rd(9'h1F0, 8'h10);
    wr(9'h1F0, 8'h00);
    rd(9'h1F0, 8'h00);
    stop_test;
  end
endmodule
